//--- rtl/sts_pkg.sv
// Shared constants for the sixteen bit timer counter.
// Assumes one synchronous clock domain; every user of these names writes sts_pkg::name.
package sts_pkg;

    // Counter width and value constants.
    localparam int          CNT_W      = 16;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_TOP    = 16'hFFFF;
    localparam int          NUM_CH     = 3;

    // Counting mode field codes.
    localparam logic [1:0]  MODE_HALT  = 2'h0;
    localparam logic [1:0]  MODE_FREE  = 2'h1;
    localparam logic [1:0]  MODE_MOD   = 2'h2;
    localparam logic [1:0]  MODE_UPDN  = 2'h3;

    // Prescaler field codes for divide by 1, 8, 32 and 128.
    localparam logic [1:0]  DIV_1      = 2'h0;
    localparam logic [1:0]  DIV_8      = 2'h1;
    localparam logic [1:0]  DIV_32     = 2'h2;
    localparam logic [1:0]  DIV_128    = 2'h3;

    // Terminal counts of the divider stages (ratio minus one).
    localparam logic [6:0]  LIM_1      = 7'h00;
    localparam logic [6:0]  LIM_8      = 7'h07;
    localparam logic [6:0]  LIM_32     = 7'h1F;
    localparam logic [6:0]  LIM_128    = 7'h7F;
    localparam logic [6:0]  DIVCNT_RST = 7'h00;

    // Tick division: the system clock tick is divided by two to the power of the select.
    function automatic logic [6:0] tick_limit(input logic [2:0] sel);
        tick_limit = 7'((8'h01 << sel) - 8'h01);
    endfunction

    // Prescaler ratio decode.
    function automatic logic [6:0] prescale_limit(input logic [1:0] sel);
        case (sel)
            DIV_1:   prescale_limit = LIM_1;
            DIV_8:   prescale_limit = LIM_8;
            DIV_32:  prescale_limit = LIM_32;
            default: prescale_limit = LIM_128;
        endcase
    endfunction

endpackage

//--- rtl/sts_prescaler.sv
// Two stage clock divider that yields the timer's active edge as a one cycle pulse.
// Assumes select inputs come from logic on sys_clk.
`timescale 1ns/1ps
module sts_prescaler (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Division selects.
    input  wire logic [2:0] tick_divide_select,
    input  wire logic [1:0] prescale_select,
    // Active timer edge.
    output logic            timer_edge
);

    typedef struct packed {
        logic [6:0] tick_cnt;
        logic [6:0] pre_cnt;
        logic       edge_pulse;
    } sts_div_state_t;

    sts_div_state_t s_q;
    sts_div_state_t s_d;
    logic           tick_hit;
    logic           pre_hit;

    // Tick stage feeds the prescaler stage; a select change takes effect at once, as each count is compared with the live select.
    always_comb
    begin
        s_d      = s_q;
        tick_hit = (s_q.tick_cnt >= sts_pkg::tick_limit(tick_divide_select));
        pre_hit  = (s_q.pre_cnt >= sts_pkg::prescale_limit(prescale_select));
        s_d.edge_pulse = tick_hit && pre_hit;
        if (tick_hit)
        begin
            s_d.tick_cnt = sts_pkg::DIVCNT_RST;
            s_d.pre_cnt  = pre_hit ? sts_pkg::DIVCNT_RST : 7'(s_q.pre_cnt + 7'h01);
        end
        else
        begin
            s_d.tick_cnt = 7'(s_q.tick_cnt + 7'h01);
        end
    end

    // State register.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s_q <= '{tick_cnt: sts_pkg::DIVCNT_RST, pre_cnt: sts_pkg::DIVCNT_RST,
                     edge_pulse: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign timer_edge = s_q.edge_pulse;

    // Divide by one at both stages gives an edge every cycle.
    edge_rate_a: assert property (@(posedge sys_clk) disable iff (reset)
        (tick_divide_select == 3'h0 && prescale_select == sts_pkg::DIV_1)[*3]
        |-> timer_edge)
        else $error("Undivided timer edge missing.");

endmodule // sts_prescaler

//--- rtl/sts_timer.sv
// Sixteen bit timer counter core with prescaler, three counting modes and three channels.
// Assumes register strobes are one cycle pulses from logic on sys_clk; channel pins are async.
`timescale 1ns/1ps
module sts_timer (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Timer control and status settings.
    input  wire logic [2:0]  tick_divide_select,
    input  wire logic [1:0]  prescale_select,
    input  wire logic [1:0]  count_mode,
    input  wire logic        overflow_irq_mask,
    input  wire logic        timer_irq_enable,
    // Counter access strobes.
    input  wire logic        count_low_rd,
    input  wire logic        count_low_wr,
    output logic [7:0]       count_low_byte,
    output logic [7:0]       count_high_byte,
    // Flag clear strobes and flags.
    input  wire logic        shared_flag_clr,
    input  wire logic        overflow_flag_clr,
    output logic             shared_timer_irq_flag,
    output logic             overflow_flag,
    output logic             irq_request,
    // Channel control and compare value writes.
    input  wire logic [2:0]  channel_control,
    input  wire logic [2:0]  channel_compare_low_wr,
    input  wire logic [2:0]  channel_compare_high_wr,
    input  wire logic [7:0]  channel_compare_wdata,
    output logic [47:0]      channel_value,
    // Channel pins.
    input  wire logic [2:0]  chan_pin_in,
    output logic [2:0]       chan_pin_out,
    output logic [2:0]       chan_pin_oe
);

    typedef struct packed {
        logic [15:0]      cnt;
        logic             down;
        logic [7:0]       low_byte;
        logic [7:0]       high_byte;
        logic             shared_flag;
        logic             ovf_flag;
        logic             irq;
        logic [2:0][15:0] value;
        logic [2:0][7:0]  low_buf;
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic [2:0]       sync3;
        logic [2:0]       pin_level;
        logic [2:0]       pin_out;
        logic [2:0]       pin_oe;
    } sts_state_t;

    sts_state_t  s_q;
    sts_state_t  s_d;
    logic        timer_edge;
    logic        running;
    logic        terminal;
    logic [15:0] cmp0;
    logic [15:0] cnt_next;
    logic [2:0]  capture_hit;

    // Active edges of the timer clock.
    sts_prescaler u_prescaler (
        .sys_clk            (sys_clk),
        .reset              (reset),
        .tick_divide_select (tick_divide_select),
        .prescale_select    (prescale_select),
        .timer_edge         (timer_edge)
    );

    // Counter, flags, byte access, channel values and pins share one next-state process.
    always_comb
    begin
        s_d      = s_q;
        cmp0     = s_q.value[0];
        running  = (count_mode != sts_pkg::MODE_HALT);
        terminal = 1'b0;
        cnt_next = s_q.cnt;
        // Capture strobes per channel, high for one cycle on a filtered rising pin edge.
        capture_hit = '0;
        // Counting step for the selected mode.
        case (count_mode)
            sts_pkg::MODE_FREE:
            begin
                cnt_next = 16'(s_q.cnt + 16'h0001);
                terminal = (s_q.cnt == sts_pkg::CNT_TOP);
            end
            sts_pkg::MODE_MOD:
            begin
                terminal = (s_q.cnt == cmp0);
                cnt_next = terminal ? sts_pkg::CNT_ZERO : 16'(s_q.cnt + 16'h0001);
            end
            sts_pkg::MODE_UPDN:
            begin
                if (!s_q.down && s_q.cnt >= cmp0 && cmp0 != sts_pkg::CNT_ZERO)
                begin
                    cnt_next  = 16'(s_q.cnt - 16'h0001);
                    s_d.down  = timer_edge ? 1'b1 : s_q.down;
                end
                else if (s_q.down && s_q.cnt != sts_pkg::CNT_ZERO)
                begin
                    cnt_next = 16'(s_q.cnt - 16'h0001);
                    terminal = (s_q.cnt == 16'h0001);
                    s_d.down = (timer_edge && terminal) ? 1'b0 : s_q.down;
                end
                else
                begin
                    cnt_next = (cmp0 == sts_pkg::CNT_ZERO) ? sts_pkg::CNT_ZERO
                                                           : 16'(s_q.cnt + 16'h0001);
                    terminal = s_q.down || (cmp0 == sts_pkg::CNT_ZERO);
                    s_d.down = timer_edge ? 1'b0 : s_q.down;
                end
            end
            default:
            begin
                cnt_next = s_q.cnt;
            end
        endcase
        // A low byte write overrides counting and restarts from zero going up.
        if (count_low_wr)
        begin
            s_d.cnt  = sts_pkg::CNT_ZERO;
            s_d.down = 1'b0;
            terminal = 1'b0;
        end
        else if (running && timer_edge)
        begin
            s_d.cnt = cnt_next;
        end
        else
        begin
            terminal = 1'b0;
        end
        // Flags: a set in the same cycle as a clear wins, so no event is lost.
        s_d.shared_flag = terminal || (s_q.shared_flag && !shared_flag_clr);
        s_d.ovf_flag    = terminal || (s_q.ovf_flag && !overflow_flag_clr);
        // The request follows the flag, so enabling it later still reports a pending event.
        s_d.irq         = s_d.ovf_flag && overflow_irq_mask && timer_irq_enable;
        // Byte views: high byte is frozen at the instant the low byte is read.
        s_d.low_byte = s_d.cnt[7:0];
        if (count_low_rd)
        begin
            s_d.high_byte = s_q.cnt[15:8];
        end
        // Pin synchroniser; a change counts once stages two and three agree.
        s_d.sync1 = chan_pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int ch = 0; ch < sts_pkg::NUM_CH; ch++)
        begin
            s_d.pin_oe[ch] = !channel_control[ch];
            // A pin change counts only once stages two and three agree; the price is
            // one more cycle of capture latency, the gain is that a glitch is ignored.
            if (s_q.sync2[ch] == s_q.sync3[ch])
            begin
                s_d.pin_level[ch] = s_q.sync3[ch];
            end
            capture_hit[ch] = s_q.sync2[ch] && s_q.sync3[ch] && !s_q.pin_level[ch];
            if (channel_compare_low_wr[ch])
            begin
                s_d.low_buf[ch] = channel_compare_wdata;
            end
            if (channel_compare_high_wr[ch])
            begin
                s_d.value[ch] = {channel_compare_wdata, s_q.low_buf[ch]};
            end
            else if (channel_control[ch] && running && capture_hit[ch])
            begin
                s_d.value[ch] = s_q.cnt;
            end
            // Compare mode toggles the pin once per matching timer edge.
            if (!channel_control[ch] && running && timer_edge && s_q.cnt == s_q.value[ch])
            begin
                s_d.pin_out[ch] = !s_q.pin_out[ch];
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.pin_oe <= 3'h7;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign count_low_byte        = s_q.low_byte;
    assign count_high_byte       = s_q.high_byte;
    assign shared_timer_irq_flag = s_q.shared_flag;
    assign overflow_flag         = s_q.ovf_flag;
    assign irq_request           = s_q.irq;
    assign channel_value         = s_q.value;
    assign chan_pin_out          = s_q.pin_out;
    assign chan_pin_oe           = s_q.pin_oe;

    // Assertions share the core clock and drop out while reset is high.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // Counting checks.
    free_step_a: assert property (
        (count_mode == sts_pkg::MODE_FREE && timer_edge && !count_low_wr
         && s_q.cnt != sts_pkg::CNT_TOP) |=> s_q.cnt == 16'($past(s_q.cnt) + 16'h0001))
        else $error("Free mode did not step up by one.");
    free_wrap_a: assert property (
        (count_mode == sts_pkg::MODE_FREE && timer_edge && !count_low_wr
         && s_q.cnt == sts_pkg::CNT_TOP)
        |=> s_q.cnt == sts_pkg::CNT_ZERO && overflow_flag && shared_timer_irq_flag)
        else $error("Free mode wrap wrong.");
    modulo_wrap_a: assert property (
        (count_mode == sts_pkg::MODE_MOD && timer_edge && !count_low_wr
         && s_q.cnt == s_q.value[0]) |=> s_q.cnt == sts_pkg::CNT_ZERO && overflow_flag)
        else $error("Modulo mode did not reset at compare value.");
    updown_turn_a: assert property (
        (count_mode == sts_pkg::MODE_UPDN && timer_edge && !count_low_wr && !s_q.down
         && s_q.cnt == s_q.value[0] && s_q.value[0] != sts_pkg::CNT_ZERO)
        |=> s_q.down && s_q.cnt == 16'($past(s_q.cnt) - 16'h0001))
        else $error("Up/down mode did not turn at compare value.");
    updown_zero_a: assert property (
        (count_mode == sts_pkg::MODE_UPDN && timer_edge && !count_low_wr && s_q.down
         && s_q.cnt == 16'h0001) |=> s_q.cnt == sts_pkg::CNT_ZERO && overflow_flag && !s_q.down)
        else $error("Up/down return to zero missed flags.");
    halt_hold_a: assert property (
        (count_mode == sts_pkg::MODE_HALT && !count_low_wr) |=> $stable(s_q.cnt))
        else $error("Halted counter moved.");
    clear_write_a: assert property (
        count_low_wr |=> s_q.cnt == sts_pkg::CNT_ZERO && count_low_byte == 8'h00)
        else $error("Low byte write did not clear counter.");
    high_latch_a: assert property (
        count_low_rd |=> count_high_byte == $past(s_q.cnt[15:8]))
        else $error("High byte not latched on low read.");
    irq_gate_a: assert property (
        irq_request |-> $past(overflow_irq_mask && timer_irq_enable))
        else $error("Request raised without mask and enable.");
    buffer_hold_a: assert property (
        (channel_compare_low_wr[0] && !channel_compare_high_wr[0] && !channel_control[0])
        |=> channel_value[15:0] == $past(channel_value[15:0]))
        else $error("Compare low write took effect early.");
    flag_set_wins_a: assert property (
        (overflow_flag_clr && terminal) |=> overflow_flag)
        else $error("Clear beat a same-cycle overflow.");
    flag_clear_a: assert property (
        (overflow_flag_clr && shared_flag_clr && !terminal)
        |=> !overflow_flag && !shared_timer_irq_flag)
        else $error("Flag clear did not take.");

    // Stepping checks away from the turning points.
    modulo_step_a: assert property (
        (count_mode == sts_pkg::MODE_MOD && timer_edge && !count_low_wr
         && s_q.cnt != s_q.value[0]) |=> s_q.cnt == 16'($past(s_q.cnt) + 16'h0001))
        else $error("Modulo mode did not step up by one.");
    updown_rise_a: assert property (
        (count_mode == sts_pkg::MODE_UPDN && timer_edge && !count_low_wr && !s_q.down
         && s_q.cnt < s_q.value[0]) |=> s_q.cnt == 16'($past(s_q.cnt) + 16'h0001))
        else $error("Up/down mode did not rise by one.");
    updown_fall_a: assert property (
        (count_mode == sts_pkg::MODE_UPDN && timer_edge && !count_low_wr && s_q.down
         && s_q.cnt != sts_pkg::CNT_ZERO) |=> s_q.cnt == 16'($past(s_q.cnt) - 16'h0001))
        else $error("Up/down mode did not fall by one.");
    high_hold_a: assert property (
        !count_low_rd |=> $stable(count_high_byte))
        else $error("High byte moved without a low read.");

    // Channel checks.
    pin_dir_a: assert property (
        1'b1 |=> chan_pin_oe == ~$past(channel_control))
        else $error("Pin direction does not follow channel control.");
    compare_toggle_a: assert property (
        (!channel_control[1] && running && timer_edge && s_q.cnt == s_q.value[1])
        |=> chan_pin_out[1] != $past(chan_pin_out[1]))
        else $error("Compare match did not toggle the pin.");
    capture_take_a: assert property (
        (channel_control[2] && running && capture_hit[2] && !channel_compare_high_wr[2])
        |=> channel_value[47:32] == $past(s_q.cnt))
        else $error("Capture did not store the count.");

    // Main scenarios.
    free_wrap_c: cover property (count_mode == sts_pkg::MODE_FREE && terminal);
    modulo_wrap_c: cover property (count_mode == sts_pkg::MODE_MOD && terminal && timer_edge);
    updown_cycle_c: cover property (s_q.down ##[1:1000] (!s_q.down && overflow_flag));
    capture_c: cover property (channel_control[2] && running && capture_hit[2]);
    compare_c: cover property (!channel_control[1] && $rose(chan_pin_out[1]));

endmodule // sts_timer

//--- verif/test_sixteen_bit_timer_counter.sv
// Self-checking bench for the sixteen bit timer counter core.
// Assumes sts_pkg and sts_timer are compiled first; the core carries its own assertions.
`timescale 1ns/1ps
module test_sixteen_bit_timer_counter;
    // Clock, reset and core inputs.
    logic        sys_clk                 = 1'h0;
    logic        reset                   = 1'h1;
    logic [2:0]  tick_divide_select      = 3'h0;
    logic [1:0]  prescale_select         = 2'h0;
    logic [1:0]  count_mode              = 2'h0;
    logic        overflow_irq_mask       = 1'h0;
    logic        timer_irq_enable        = 1'h0;
    logic        count_low_rd            = 1'h0;
    logic        count_low_wr            = 1'h0;
    logic        shared_flag_clr         = 1'h0;
    logic        overflow_flag_clr       = 1'h0;
    logic [2:0]  channel_control         = 3'h0;
    logic [2:0]  channel_compare_low_wr  = 3'h0;
    logic [2:0]  channel_compare_high_wr = 3'h0;
    logic [7:0]  channel_compare_wdata   = 8'h00;
    logic [2:0]  chan_pin_in             = 3'h0;
    // Core outputs.
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic        shared_timer_irq_flag;
    logic        overflow_flag;
    logic        irq_request;
    logic [47:0] channel_value;
    logic [2:0]  chan_pin_out;
    logic [2:0]  chan_pin_oe;
    // Bookkeeping.
    int          err_count               = 0;
    int          tests_run               = 0;
    logic [15:0] v;
    int          d;
    int          tk[6]                   = '{0, 0, 0, 0, 2, 3};
    int          pk[6]                   = '{0, 1, 2, 3, 0, 1};
    int          rt[4]                   = '{1, 8, 32, 128};

    sts_timer i_dut (
        .sys_clk, .reset, .tick_divide_select, .prescale_select, .count_mode,
        .overflow_irq_mask, .timer_irq_enable, .count_low_rd, .count_low_wr,
        .count_low_byte, .count_high_byte, .shared_flag_clr, .overflow_flag_clr,
        .shared_timer_irq_flag, .overflow_flag, .irq_request, .channel_control,
        .channel_compare_low_wr, .channel_compare_high_wr, .channel_compare_wdata,
        .channel_value, .chan_pin_in, .chan_pin_out, .chan_pin_oe
    );

    // The clock runs at 100 MHz.
    always #5 sys_clk = ~sys_clk;

    // Inputs always change 1 ns after an edge so no race with the core's sampling.
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic chkf(input logic [1:0] exp);
        chk("flags", {14'h0000, exp}, {14'h0000, shared_timer_irq_flag, overflow_flag});
    endtask

    task automatic results;
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Low byte write strobe; its data is ignored by the core.
    task automatic clr_cnt;
        count_low_wr = 1'h1;
        step(1);
        count_low_wr = 1'h0;
    endtask

    // Reads low then high, the only order in which the pair is coherent.
    task automatic rd_cnt(output logic [15:0] val);
        count_low_rd = 1'h1;
        step(1);
        count_low_rd = 1'h0;
        step(1);
        val = {count_high_byte, count_low_byte};
    endtask

    // Counts in one mode for n cycles, halts, then reads and compares.
    task automatic run_chk(input logic [1:0] m, input int n, input logic [15:0] exp);
        logic [15:0] got;
        count_mode = m;
        step(n);
        count_mode = sts_pkg::MODE_HALT;
        step(2);
        rd_cnt(got);
        chk("count", exp, got);
    endtask

    // Compare value byte write to one channel; hi selects the high byte.
    task automatic wr_cv(input int ch, input logic hi, input logic [7:0] dat);
        channel_compare_wdata   = dat;
        channel_compare_low_wr  = hi ? 3'h0 : 3'(1 << ch);
        channel_compare_high_wr = hi ? 3'(1 << ch) : 3'h0;
        step(1);
        channel_compare_low_wr  = 3'h0;
        channel_compare_high_wr = 3'h0;
    endtask

    task automatic clr_flags;
        shared_flag_clr   = 1'h1;
        overflow_flag_clr = 1'h1;
        step(1);
        shared_flag_clr   = 1'h0;
        overflow_flag_clr = 1'h0;
        step(1);
    endtask

    // Main sequence; reset is held for 12 cycles.
    initial
    begin
        step(12);
        chk("oe_in_reset", 16'h0007, {13'h0000, chan_pin_oe});
        chk("bytes_in_reset", 16'h0000, {count_high_byte, count_low_byte});
        chkf(2'h0);
        reset = 1'h0;
        step(2);
        // Counting, halting and clearing with an edge every cycle.
        clr_cnt();
        run_chk(sts_pkg::MODE_FREE, 37, 16'h0025);
        step(20);
        rd_cnt(v);
        chk("halt_hold", 16'h0025, v);
        clr_cnt();
        rd_cnt(v);
        chk("clear_halted", 16'h0000, v);
        // The high byte only moves on a low byte read, not with the counter.
        run_chk(sts_pkg::MODE_FREE, 300, 16'h012C);
        clr_cnt();
        chk("high_held", 16'h0001, {8'h00, count_high_byte});
        // A window of four periods holds exactly four edges at any phase.
        for (int i = 0; i < 6; i++)
        begin
            tick_divide_select = 3'(tk[i]);
            prescale_select    = 2'(pk[i]);
            d                  = rt[pk[i]] << tk[i];
            step(300);
            clr_cnt();
            run_chk(sts_pkg::MODE_FREE, 4 * d, 16'h0004);
        end
        tick_divide_select = 3'h0;
        prescale_select    = 2'h0;
        step(300);
        // Free-running wrap past 0xFFFF and the request gating.
        overflow_irq_mask = 1'h1;
        clr_cnt();
        run_chk(sts_pkg::MODE_FREE, 65541, 16'h0005);
        chkf(2'h3);
        chk("irq_no_enable", 16'h0000, {15'h0000, irq_request});
        timer_irq_enable = 1'h1;
        step(2);
        chk("irq_both", 16'h0001, {15'h0000, irq_request});
        overflow_irq_mask = 1'h0;
        step(2);
        chk("irq_no_mask", 16'h0000, {15'h0000, irq_request});
        overflow_irq_mask = 1'h1;
        clr_flags();
        chkf(2'h0);
        // Channel 0 top value; the low byte alone must not take effect.
        wr_cv(0, 1'h0, 8'h05);
        step(1);
        chk("ch0_low_only", 16'h0000, channel_value[15:0]);
        wr_cv(0, 1'h1, 8'h00);
        step(1);
        chk("ch0_value", 16'h0005, channel_value[15:0]);
        // Modulo with top 5: the count after k edges is k mod 6.
        clr_cnt();
        run_chk(sts_pkg::MODE_MOD, 5, 16'h0005);
        chkf(2'h0);
        run_chk(sts_pkg::MODE_MOD, 3, 16'h0002);
        chkf(2'h3);
        chk("irq_mod", 16'h0001, {15'h0000, irq_request});
        clr_flags();
        // Up/down with top 5 ramps 0..5..0.
        clr_cnt();
        run_chk(sts_pkg::MODE_UPDN, 7, 16'h0003);
        chkf(2'h0);
        run_chk(sts_pkg::MODE_UPDN, 3, 16'h0000);
        chkf(2'h3);
        clr_flags();
        // A low byte write beats counting while running.
        count_mode = sts_pkg::MODE_FREE;
        step(50);
        clr_cnt();
        count_mode = sts_pkg::MODE_HALT;
        step(2);
        rd_cnt(v);
        chk("clear_running", 16'h0000, v);
        // Compare channels drive their pins, capture channels release them.
        channel_control = 3'h5;
        step(3);
        chk("pin_oe", 16'h0002, {13'h0000, chan_pin_oe});
        // A reset in mid-run returns every output to its reset value.
        reset = 1'h1;
        step(3);
        chk("oe_mid_reset", 16'h0007, {13'h0000, chan_pin_oe});
        chk("pins_mid_reset", 16'h0000, {13'h0000, chan_pin_out});
        reset = 1'h0;
        step(2);
        // Channel 1 compares at 3; the channel 2 rise needs three sync stages, so
        // the capture sees the count two edges after the clear.
        wr_cv(1, 1'h0, 8'h03);
        wr_cv(1, 1'h1, 8'h00);
        count_mode  = sts_pkg::MODE_FREE;
        chan_pin_in = 3'h4;
        clr_cnt();
        step(6);
        count_mode = sts_pkg::MODE_HALT;
        chk("ch2_capture", 16'h0002, channel_value[47:32]);
        chk("ch1_compare", 16'h0003, channel_value[31:16]);
        chk("pins_out", 16'h0002, {13'h0000, chan_pin_out});
        // With top 0 modulo flags every edge, so a clear on a flagging edge loses.
        clr_cnt();
        count_mode = sts_pkg::MODE_MOD;
        step(3);
        clr_flags();
        chkf(2'h3);
        count_mode = sts_pkg::MODE_HALT;
        clr_flags();
        chkf(2'h0);
        results();
    end
endmodule // test_sixteen_bit_timer_counter
